// ---- wdt_pkg.sv ----
// Constants shared by the watchdog timer control register and timebase.
// How it works
// - Clear arm bit stops all timeout actions.
// - Missed re-arm within period fires reset/interrupt.
// - Sixteen-bit counter steps on 32.768 kHz.
// - Timeout select field is bits 7 to 4.
// - Period is 512 times two-power-select slow cycles.
// - Control writes ignored unless unlock precedes each.
// - Control register at C0H, bit addressable, 10H.
// - Arming clears counter; several events clear arm.
// - Action select high gives interrupt, low reset; select code 8 always resets.
// - Timeout flag set, survives watchdog reset.
package wdt_pkg;

   // Register placement and power-on value.
   localparam logic [7:0] WDT_CTRL_ADDR  = 8'hC0;
   localparam logic [7:0] WDT_CTRL_RESET = 8'h10;

   // Field positions inside the control register.
   localparam int WDT_SEL_MSB    = 7;
   localparam int WDT_SEL_LSB    = 4;
   localparam int WDT_ACTION_POS = 3;
   localparam int WDT_FLAG_POS   = 2;
   localparam int WDT_ARM_POS    = 1;
   localparam int WDT_UNLOCK_POS = 0;

   // Timeout select codes: 0..7 are timed, 8 fires at once, 9..15 are reserved.
   localparam logic [3:0] WDT_SEL_MAX_TIMED = 4'h7;
   localparam logic [3:0] WDT_SEL_IMMEDIATE = 4'h8;

   // Shortest period in slow clock cycles, two to the ninth.
   localparam logic [16:0] WDT_BASE_CYCLES = 17'h0_0200;

   // Slow timebase rate in hertz.
   localparam int WDT_LF_HZ = 32768;

endpackage

// ---- wdt_tick.sv ----
// Synchroniser and edge detector that turns the slow clock pin into an mclk pulse.
`timescale 1ns/1ps
module wdt_tick (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic lf_clk_in,
   output logic      tick_q
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // The pin is asynchronous to mclk, so only the second stage is looked at.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
         tick_q  <= 1'b0;
      end else begin
         sync1_q <= lf_clk_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         tick_q  <= sync2_q & ~prev_q;
      end
   end

endmodule

// ---- wdt_top.sv ----
// Watchdog timer: guarded control register on the SFR port, timebase and timeout actions.
`timescale 1ns/1ps
module wdt_top (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       lf_clk_in,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] bit_addr,
   input  wire logic       bit_wr,
   input  wire logic       bit_wdata,
   input  wire logic       hw_rst,
   input  wire logic       supply_monitor_irq,
   output logic [7:0]      sfr_rdata_q,
   output logic            wd_reset_req_q,
   output logic            wd_irq_q,
   output logic            wd_armed_q
);

   // Control register fields.
   logic [3:0]  timeout_select_field_q;
   logic [3:0]  timeout_select_field_d;
   logic        timeout_action_select_q;
   logic        timeout_action_select_d;
   logic        wd_timeout_flag_q;
   logic        wd_timeout_flag_d;
   logic        wd_arm_bit_q;
   logic        wd_arm_bit_d;
   logic        write_unlock_bit_q;
   logic        write_unlock_bit_d;

   // Timebase.
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        lf_tick;

   // Decode and selection.
   wire  [7:0]  wd_control_reg;
   wire         byte_hit;
   wire         bit_hit;
   wire  [2:0]  bit_sel;
   wire         unlock_bit_wr;
   wire         guarded_wr;
   wire         wr_ok;
   wire         other_wr;
   wire  [7:0]  bit_merge;
   wire  [7:0]  wr_val;
   wire         arm_set_evt;
   wire         rd_hit;
   wire  [7:0]  rd_val;
   wire         relock;
   wire         arm_hw_clr;

   // Timeout detection.
   wire  [16:0] span;
   wire  [16:0] span_m1;
   wire  [15:0] limit;
   wire         sel_timed;
   wire         sel_immed;
   wire         count_hit;
   wire         timeout_evt;
   wire         rst_fire;
   wire         irq_fire;

   wdt_tick u_tick (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .lf_clk_in (lf_clk_in),
      .tick_q    (lf_tick)
   );

   assign wd_control_reg = {timeout_select_field_q,
                            timeout_action_select_q,
                            wd_timeout_flag_q,
                            wd_arm_bit_q,
                            write_unlock_bit_q};

   // Byte access at the register address, bit access at any of its eight bit addresses.
   assign byte_hit = sfr_wr && (sfr_addr == wdt_pkg::WDT_CTRL_ADDR);
   assign bit_hit  = bit_wr && (bit_addr[7:3] == wdt_pkg::WDT_CTRL_ADDR[7:3]);
   assign bit_sel  = bit_addr[2:0];
   assign rd_hit   = sfr_rd && (sfr_addr == wdt_pkg::WDT_CTRL_ADDR);

   // Other addresses read as zero so that several registers' read data can be ORed.
   assign rd_val   = rd_hit ? wd_control_reg : 8'h00;

   // Setting or clearing the unlock bit itself with a bit write is always allowed; a byte write cannot set it.
   assign unlock_bit_wr = bit_hit && (bit_sel == 3'(wdt_pkg::WDT_UNLOCK_POS));
   assign guarded_wr    = byte_hit || (bit_hit && !unlock_bit_wr);
   assign wr_ok         = guarded_wr && write_unlock_bit_q;

   // Any other SFR write means the instruction after the unlock was not ours.
   assign other_wr = sfr_wr && !byte_hit;
   assign relock   = guarded_wr || other_wr;

   // A bit write is a read-modify-write of the stored word.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_merge
         assign bit_merge[gi] = (bit_sel == 3'(gi)) ? bit_wdata : wd_control_reg[gi];
      end
   endgenerate

   assign wr_val      = byte_hit ? sfr_wdata : bit_merge;
   assign arm_set_evt = wr_ok && wr_val[wdt_pkg::WDT_ARM_POS];

   // Terminal count is 512 shifted by the select value, less one.
   assign span      = wdt_pkg::WDT_BASE_CYCLES << timeout_select_field_q[2:0];
   assign span_m1   = span - 17'h0_0001;
   assign limit     = span_m1[15:0];
   // Reserved codes 9 to 15 match neither test, so an armed watchdog never expires on them.
   assign sel_timed = (timeout_select_field_q <= wdt_pkg::WDT_SEL_MAX_TIMED);
   assign sel_immed = (timeout_select_field_q == wdt_pkg::WDT_SEL_IMMEDIATE);
   assign count_hit = sel_timed && lf_tick && (count_q == limit);

   // A fresh re-arm in the same cycle wins over an expiring count.
   assign timeout_evt = wd_arm_bit_q && !arm_set_evt && (count_hit || sel_immed);

   // The immediate code always resets, regardless of the action bit.
   assign rst_fire = timeout_evt && (sel_immed || !timeout_action_select_q);
   assign irq_fire = timeout_evt && !sel_immed && timeout_action_select_q;

   // Every hardware source that clears the arm bit; hw_rst and supply_monitor_irq beat a software set, which suppresses rst_fire.
   assign arm_hw_clr = hw_rst || supply_monitor_irq || rst_fire;

   always_comb begin
      timeout_select_field_d  = timeout_select_field_q;
      timeout_action_select_d = timeout_action_select_q;
      if (hw_rst) begin
         timeout_select_field_d  = wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_SEL_MSB:
                                                           wdt_pkg::WDT_SEL_LSB];
         timeout_action_select_d = wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_ACTION_POS];
      end else if (wr_ok) begin
         timeout_select_field_d  = wr_val[wdt_pkg::WDT_SEL_MSB:wdt_pkg::WDT_SEL_LSB];
         timeout_action_select_d = wr_val[wdt_pkg::WDT_ACTION_POS];
      end
   end

   // Reset and supply monitor clears of the arm bit win over a software set in the same cycle.
   always_comb begin
      wd_arm_bit_d = wd_arm_bit_q;
      if (arm_hw_clr) begin
         wd_arm_bit_d = 1'b0;
      end else if (wr_ok) begin
         wd_arm_bit_d = wr_val[wdt_pkg::WDT_ARM_POS];
      end
   end

   // The flag is cleared by software or hardware reset, never by the watchdog reset.
   always_comb begin
      wd_timeout_flag_d = wd_timeout_flag_q;
      if (hw_rst) begin
         wd_timeout_flag_d = 1'b0;
      end else if (timeout_evt) begin
         wd_timeout_flag_d = 1'b1;
      end else if (wr_ok) begin
         wd_timeout_flag_d = wr_val[wdt_pkg::WDT_FLAG_POS];
      end
   end

   // One guarded write per unlock; an intervening write elsewhere also relocks.
   always_comb begin
      write_unlock_bit_d = write_unlock_bit_q;
      if (hw_rst || rst_fire) begin
         write_unlock_bit_d = 1'b0;
      end else if (unlock_bit_wr) begin
         write_unlock_bit_d = bit_wdata;
      end else if (relock) begin
         write_unlock_bit_d = 1'b0;
      end
   end

   // The counter only runs while armed and restarts on every re-arm or timeout.
   always_comb begin
      count_d = count_q;
      if (!wd_arm_bit_q || arm_set_evt || timeout_evt) begin
         count_d = 16'h0_000;
      end else if (lf_tick) begin
         count_d = count_q + 16'h0_001;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         timeout_select_field_q  <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_SEL_MSB:
                                                            wdt_pkg::WDT_SEL_LSB];
         timeout_action_select_q <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_ACTION_POS];
         wd_timeout_flag_q       <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_FLAG_POS];
         wd_arm_bit_q            <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_ARM_POS];
         write_unlock_bit_q      <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_UNLOCK_POS];
      end else begin
         timeout_select_field_q  <= timeout_select_field_d;
         timeout_action_select_q <= timeout_action_select_d;
         wd_timeout_flag_q       <= wd_timeout_flag_d;
         wd_arm_bit_q            <= wd_arm_bit_d;
         write_unlock_bit_q      <= write_unlock_bit_d;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= 16'h0_000;
      end else begin
         count_q <= count_d;
      end
   end

   // Outputs are registered so the reset generator sees a clean one-cycle pulse.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata_q    <= 8'h00;
         wd_reset_req_q <= 1'b0;
         wd_irq_q       <= 1'b0;
         wd_armed_q     <= 1'b0;
      end else begin
         sfr_rdata_q    <= rd_val;
         wd_reset_req_q <= rst_fire;
         wd_irq_q       <= irq_fire;
         wd_armed_q     <= wd_arm_bit_d;
      end
   end

endmodule

// ---- wdt_properties.sv ----
// Port-level checker for the watchdog timer top module.
`timescale 1ns/1ps
module wdt_properties (
   input wire logic       mclk,
   input wire logic       arst_n,
   input wire logic       lf_clk_in,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_rd,
   input wire logic [7:0] bit_addr,
   input wire logic       bit_wr,
   input wire logic       bit_wdata,
   input wire logic       hw_rst,
   input wire logic       supply_monitor_irq,
   input wire logic [7:0] sfr_rdata_q,
   input wire logic       wd_reset_req_q,
   input wire logic       wd_irq_q,
   input wire logic       wd_armed_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // A write in the pulse cycle could legally clear the flag, so it is excluded.
   sequence s_fire_clean;
      (wd_reset_req_q || wd_irq_q) && !sfr_wr && !bit_wr && !hw_rst;
   endsequence
   sequence s_rd_reg;
      sfr_rd && sfr_addr == 8'hC0;
   endsequence
   a_quiet_disarmed: assert property (
      !wd_armed_q ##1 !wd_armed_q |-> !wd_reset_req_q && !wd_irq_q) else $error("fire while off");
   a_irq_single: assert property (wd_irq_q |=> !wd_irq_q) else $error("irq too long");
   a_rst_single: assert property (wd_reset_req_q |=> !wd_reset_req_q) else $error("rst long");
   a_rst_disarms: assert property (wd_reset_req_q |-> !wd_armed_q) else $error("arm kept");
   a_flag_after_fire: assert property (
      s_fire_clean ##1 s_rd_reg |=> sfr_rdata_q[2]) else $error("flag not set");
   a_arm_mirror: assert property (
      s_rd_reg |=> sfr_rdata_q[1] == $past(wd_armed_q)) else $error("arm mismatch");
   a_idle_read_zero: assert property (
      !(sfr_rd && sfr_addr == 8'hC0) |=> sfr_rdata_q == 8'h00) else $error("stray data");
   a_supply_clears: assert property (supply_monitor_irq |=> !wd_armed_q) else $error("arm kept");
   a_hw_rst_value: assert property (
      hw_rst ##1 s_rd_reg |=> sfr_rdata_q == 8'h10) else $error("bad reset value");
endmodule
bind wdt_top wdt_properties wdt_properties_inst (
   .mclk(mclk), .arst_n(arst_n), .lf_clk_in(lf_clk_in), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .bit_addr(bit_addr),
   .bit_wr(bit_wr), .bit_wdata(bit_wdata), .hw_rst(hw_rst),
   .supply_monitor_irq(supply_monitor_irq), .sfr_rdata_q(sfr_rdata_q),
   .wd_reset_req_q(wd_reset_req_q), .wd_irq_q(wd_irq_q), .wd_armed_q(wd_armed_q));

// ---- tb_top.sv ----
// Self-checking bench for the watchdog timer: guarded writes, timeouts and clears.
`timescale 1ns/1ps
module tb_top;
   logic       mclk = 0, arst_n = 0, lf_clk_in = 0, sfr_wr = 0, sfr_rd = 0;
   logic       bit_wr = 0, bit_wdata = 0, hw_rst = 0, supply_monitor_irq = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata_q;
   logic       wd_reset_req_q, wd_irq_q, wd_armed_q;
   int         n_fail = 0, tests_run = 0, m = 'h10, c = 0, seed = 32'h3ea8;
   wdt_top wdt_top_inst (
      .mclk(mclk), .arst_n(arst_n), .lf_clk_in(lf_clk_in), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .bit_addr(bit_addr),
      .bit_wr(bit_wr), .bit_wdata(bit_wdata), .hw_rst(hw_rst),
      .supply_monitor_irq(supply_monitor_irq), .sfr_rdata_q(sfr_rdata_q),
      .wd_reset_req_q(wd_reset_req_q), .wd_irq_q(wd_irq_q), .wd_armed_q(wd_armed_q));
   initial forever #4 mclk = ~mclk;
   // Slow clock runs at one eighth of mclk so that timeouts stay short.
   initial begin
      forever begin
         repeat (4) @(posedge mclk);
         lf_clk_in <= ~lf_clk_in;
      end
   end
   initial begin
      #500000;
      n_fail++;
      summarize();
   end
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(posedge mclk);
      sfr_rd <= 1;
      sfr_addr <= a;
      @(posedge mclk);
      sfr_rd <= 0;
      hw_rst <= 0;
      #1 chk(sfr_rdata_q, exp);
   endtask
   // Bit zero is the unlock itself; any other bit is a guarded write.
   task automatic bw(logic [7:0] a, logic v);
      @(posedge mclk);
      bit_wr <= 1;
      bit_addr <= a;
      bit_wdata <= v;
      @(posedge mclk);
      bit_wr <= 0;
      if (a[2:0] == 3'h0) m[0] = v;
      else begin
         if (m[0]) m[a[2:0]] = v;
         m[0] = 0;
      end
   endtask
   task automatic unl();
      bw(8'hC0, 1'b1);
   endtask
   // Every guarded write relocks, accepted or not; a write elsewhere relocks too.
   task automatic wa(logic [7:0] a, logic [7:0] v);
      @(posedge mclk);
      sfr_wr <= 1;
      sfr_addr <= a;
      sfr_wdata <= v;
      @(posedge mclk);
      sfr_wr <= 0;
      if (a == 8'hC0 && m[0]) m = v;
      m = m & 'hFE;
   endtask
   task automatic wr(logic [7:0] v);
      wa(8'hC0, v);
   endtask
   task automatic wf(int lim);
      c = 0;
      while (c < lim && wd_irq_q !== 1 && wd_reset_req_q !== 1) begin
         @(posedge mclk);
         #1 c++;
      end
      if (c < lim) m = m | 4;
      if (wd_reset_req_q === 1) m = m & 'hFC;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      arst_n <= 1;
      rd(8'hC0, 8'(m));
      rd(8'hC1, 8'h00);
      repeat (4) begin
         wr(8'($random(seed)));
         rd(8'hC0, 8'(m));
      end
      $display("locked writes done");
      unl();
      wr(8'h0A);
      wr(8'h00);
      rd(8'hC0, 8'(m));
      wf(9000);
      chk(8'(c > 4070 && c < 4110), 8'h01);
      rd(8'hC0, 8'(m));
      wf(9000);
      chk(8'(c > 4080 && c < 4110 && wd_armed_q === 1), 8'h01);
      $display("interrupt mode done");
      unl();
      wr(8'h12);
      wf(20000);
      chk(8'(c > 8180 && c < 8210 && wd_reset_req_q === 1), 8'h01);
      rd(8'hC0, 8'(m));
      $display("reset mode done");
      unl();
      wr(8'h02);
      repeat (3) begin
         repeat (3000) @(posedge mclk);
         unl();
         wr(8'h02);
      end
      wf(3500);
      chk(8'(c == 3500), 8'h01);
      @(posedge mclk);
      supply_monitor_irq <= 1;
      @(posedge mclk);
      supply_monitor_irq <= 0;
      m = m & 'hFD;
      wf(6000);
      chk(8'(c == 6000), 8'h01);
      rd(8'hC0, 8'(m));
      bw(8'hC1, 1'b1);
      rd(8'hC0, 8'(m));
      unl();
      bw(8'hC1, 1'b1);
      rd(8'hC0, 8'(m));
      unl();
      wa(8'h80, 8'h00);
      wr(8'h00);
      rd(8'hC0, 8'(m));
      unl();
      wr(8'hA2);
      wf(4200);
      chk(8'(c == 4200), 8'h01);
      unl();
      wr(8'h8A);
      wf(8);
      chk(8'(c == 1 && wd_reset_req_q === 1), 8'h01);
      rd(8'hC0, 8'(m));
      $display("bit writes and select codes done");
      unl();
      wr(8'h0A);
      @(posedge mclk);
      hw_rst <= 1;
      rd(8'hC0, 8'h10);
      $display("rearm and clears done");
      summarize();
   end
endmodule
